// ===== bench/bus_peer_model.sv
// peer processors and shared open drain wires around the arbiter
`timescale 1ns/1ps
module bus_peer_model
  import bus_arb_pkg::*;
(
  // device drive and peer wishes
  input wire req_vec_t i_own_n,
  input wire req_vec_t i_own_oe,
  input wire req_vec_t i_peer_want,
  input wire logic i_cpa_n,
  input wire logic i_cpa_oe,
  input wire logic i_peer_cpa,
  // resolved wires
  output req_vec_t o_lines_n,
  output logic o_cpa_n
);
  // ==========================================================
  // wire resolution
  // pulled-up lines: unused ones stay high, each pulled low by a driver
  assign o_lines_n = ~((i_own_oe & ~i_own_n) | i_peer_want);
  // one shared priority wire with pull-up, any party pulls it low
  assign o_cpa_n = ~((i_cpa_oe & ~i_cpa_n) | i_peer_cpa);
endmodule

// ===== bench/external_bus_arbitration_test.sv
// testbench for the external bus arbitration block
`timescale 1ns/1ps
module external_bus_arbitration_test;
  import bus_arb_pkg::*;
  // ==========================================================
  // stimulus and observed signals
  logic clk = 1'b0, rst_n = 1'b0, hbr_n = 1'b1, cs_n = 1'b1, rotating_priority_select = 1'b0;
  logic dr1_n = 1'b1, dr2_n = 1'b1, want = 1'b0, bg = 1'b0, cpri = 1'b0;
  logic wt = 1'b0, rds = 1'b0, g7 = 1'b0, g6 = 1'b0, pcpa = 1'b0;
  req_vec_t peer = 6'h00;
  req_vec_t lines_n, req_n, req_oe;
  proc_id_t id = 3'h3; // changed only while reset is held
  logic grant_n, grant_oe, rdy, rdy_oe, cpa_n_o, cpa_oe, cpa_w;
  logic dg1_n, dg2_n, r7, r6, drive, master;
  int bad_count = 0, tests_run = 0, cycles = 0;
  // 40 MHz clock
  always #12.5 clk = ~clk;
  external_bus_arbitration dut (
    .i_clock(clk), .i_rst_n(rst_n),
    .i_host_bus_request_n(hbr_n), .i_chip_select_n(cs_n),
    .o_host_bus_grant_n(grant_n), .o_host_bus_grant_oe(grant_oe),
    .o_host_access_ready(rdy), .o_host_access_ready_oe(rdy_oe),
    .i_processor_bus_request_n(lines_n),
    .o_processor_bus_request_n(req_n),
    .o_processor_bus_request_oe(req_oe),
    .i_processor_number_inputs(id), .i_rotating_priority_select(rotating_priority_select),
    .i_core_priority_access_n(cpa_w), .o_core_priority_access_n(cpa_n_o),
    .o_core_priority_access_oe(cpa_oe),
    .i_dma_request_one_n(dr1_n), .i_dma_request_two_n(dr2_n),
    .o_dma_grant_one_n(dg1_n), .o_dma_grant_two_n(dg2_n),
    .i_bus_wanted(want), .i_dma_background(bg), .i_core_priority(cpri),
    .i_access_wait(wt), .i_ready_drive_select(rds),
    .i_dma_channel7_grant(g7), .i_dma_channel6_grant(g6),
    .o_dma_channel7_request(r7), .o_dma_channel6_request(r6),
    .o_bus_drive(drive), .o_bus_master(master)
  );
  bus_peer_model peers (
    .i_own_n(req_n), .i_own_oe(req_oe), .i_peer_want(peer),
    .i_cpa_n(cpa_n_o), .i_cpa_oe(cpa_oe), .i_peer_cpa(pcpa),
    .o_lines_n(lines_n), .o_cpa_n(cpa_w)
  );
  // ==========================================================
  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      $display("MISMATCH timeout expected end seen hang");
      finish_test();
    end
  end
  // ==========================================================
  // tasks
  task tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task chk(input string nm, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %b seen %b", nm, exp, got);
    end
  endtask
  task chkv(input string nm, input req_vec_t exp, input req_vec_t got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one host ready step: select, wait, drive select, expected oe, level
  task rdy_step(input logic c, w, d, eo, el);
    cs_n = c;
    wt = w;
    rds = d;
    tick(2);
    chk("ready_oe", eo, rdy_oe);
    if (eo) chk("ready", el, rdy);
  endtask
  // one dma step: external requests and internal grants, high active
  task dma_step(input logic d1, d2, c7, c6);
    dr1_n = ~d1;
    dr2_n = ~d2;
    g7 = c7;
    g6 = c6;
    tick(2);
    chk("ch7_req", d1, r7);
    chk("ch6_req", d2, r6);
    chk("grant_one", ~c7, dg1_n);
    chk("grant_two", ~c6, dg2_n);
  endtask
  // line two was last master, lines one and three then compete
  task rotate(input logic rot);
    want = 1'b0;
    peer = 6'h00;
    rotating_priority_select = rot; // same cycle on every processor
    tick(4);
    peer = 6'h02;
    tick(4);
    peer = 6'h03;
    want = 1'b1;
    tick(4);
    chk("held", 1'b0, master);
    peer = 6'h01;
    tick(4);
    chk("rotate", rot, master);
    $display("test rotate %b done", rot);
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    tick(16);
    chk("grant_oe", 1'b0, grant_oe);
    chkv("req_oe", 6'h00, req_oe);
    rst_n = 1'b1;
    peer = 6'h01;
    want = 1'b1;
    tick(4);
    chkv("req_oe", 6'h04, req_oe);
    chk("own_line", 1'b0, req_n[3]);
    chk("fixed_lose", 1'b0, master);
    chk("slave_grant_oe", 1'b0, grant_oe);
    peer = 6'h00;
    tick(4);
    chk("master", 1'b1, master);
    chk("master_grant_oe", 1'b1, grant_oe);
    $display("test arbitration done");
    hbr_n = 1'b0;
    peer = 6'h01;
    tick(1);
    chk("grant_early", 1'b1, grant_n);
    tick(2);
    chk("grant", 1'b0, grant_n);
    chk("float", 1'b0, drive);
    tick(8);
    chk("grant_held", 1'b0, grant_n);
    chk("host_wins", 1'b1, master);
    rdy_step(1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
    rdy_step(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    rdy_step(1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
    rdy_step(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
    hbr_n = 1'b1;
    tick(2);
    chk("grant_off", 1'b1, grant_n);
    chk("drive_back", 1'b1, drive);
    rdy_step(1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
    cs_n = 1'b1;
    $display("test host done");
    dma_step(1'b1, 1'b0, 1'b0, 1'b1);
    dma_step(1'b0, 1'b1, 1'b1, 1'b0);
    dma_step(1'b0, 1'b0, 1'b0, 1'b0);
    $display("test dma done");
    bg = 1'b1;
    pcpa = 1'b1;
    // own line is released for one edge, then rearbitration follows
    tick(1);
    chk("yield", 1'b1, lines_n[3]);
    pcpa = 1'b0;
    bg = 1'b0;
    tick(4);
    chk("slave", 1'b0, master);
    cpri = 1'b1;
    tick(2);
    chk("cpa_oe", 1'b1, cpa_oe);
    chk("cpa_wire", 1'b0, cpa_w);
    cpri = 1'b0;
    $display("test core priority done");
    rotate(1'b1);
    rotate(1'b0);
    // single processor system: number zero set while reset is held
    rst_n = 1'b0;
    id = 3'h0;
    peer = 6'h00;
    tick(2);
    rst_n = 1'b1;
    tick(2);
    chkv("single_req_oe", 6'h00, req_oe);
    chk("single_master", 1'b1, master);
    hbr_n = 1'b0;
    tick(3);
    chk("single_grant", 1'b0, grant_n);
    $display("test single done");
    finish_test();
  end
endmodule

// ===== hw/bus_arb_pkg.sv
// types shared by the external bus arbitration files
`include "bus_arb_regs.svh"
package bus_arb_pkg;
  // processor number as read on the number inputs
  typedef logic [`ARB_ID_W-1:0] proc_id_t;
  // one bit per processor request line, line one at bit 1
  typedef logic [`ARB_LINES:1] req_vec_t;
  // host hand-over sequence
  typedef enum logic [1:0] {
    HOST_IDLE,
    HOST_RELEASE,
    HOST_GRANT
  } host_state_t;
endpackage

// ===== hw/bus_arb_regs.svh
// constants for the external bus arbitration block
`ifndef BUS_ARB_REGS_SVH
`define BUS_ARB_REGS_SVH
// ==========================================================
// request lines and processor numbers
`define ARB_LINES 6
`define ARB_ID_W 3
`define ARB_ID_NONE 3'h0
`define ARB_LINE_FIRST 3'h1
`define ARB_LINE_SECOND 3'h2
`define ARB_LINE_LAST 3'h6
// ==========================================================
// dma channels served by the external request pairs
`define DMA_CH_PAIR_ONE 7
`define DMA_CH_PAIR_TWO 6
`endif

// ===== hw/external_bus_arbitration.sv
// shared external bus arbitration and host access handshake
//
// Overview of operation
// [R1] on host request, master releases then grants
// [R2] releasing floats address, data, select, strobes
// [R3] host request beats every processor request
// [R4] grant held low until host request withdrawn
// [R5] only bus master drives the host grant
// [R6] host selects this device by chip select
// [R7] ready low inserts waits on host access
// [R8] ready open drain after reset, bit enables drive
// [R9] ready driven only with select and request
// [R10] drive own request line, sample the others
// [R11] number inputs pick line; zero means single
// [R12] number inputs change only under reset
// [R13] unused lines high; own line never tied
// [R14] priority select high rotates, low fixed
// [R15] priority select equal and synchronous everywhere
// [R16] slave core priority pre-empts background dma
// [R17] core priority is one shared open drain line
// [R18] dma pair one serves channel 7, two channel 6
// [R19] fixed priority grants lowest asserted line
// [R20] rotating priority puts last master lowest
`timescale 1ns/1ps
`include "bus_arb_regs.svh"
module external_bus_arbitration
  import bus_arb_pkg::*;
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // host handshake pins
  input wire logic i_host_bus_request_n,
  input wire logic i_chip_select_n,
  output logic o_host_bus_grant_n,
  output logic o_host_bus_grant_oe,
  output logic o_host_access_ready,
  output logic o_host_access_ready_oe,
  // multiprocessor arbitration pins
  input wire req_vec_t i_processor_bus_request_n,
  output req_vec_t o_processor_bus_request_n,
  output req_vec_t o_processor_bus_request_oe,
  input wire proc_id_t i_processor_number_inputs,
  input wire logic i_rotating_priority_select,
  input wire logic i_core_priority_access_n,
  output logic o_core_priority_access_n,
  output logic o_core_priority_access_oe,
  // external dma handshake pins
  input wire logic i_dma_request_one_n,
  input wire logic i_dma_request_two_n,
  output logic o_dma_grant_one_n,
  output logic o_dma_grant_two_n,
  // core and configuration side
  input wire logic i_bus_wanted,
  input wire logic i_dma_background,
  input wire logic i_core_priority,
  input wire logic i_access_wait,
  input wire logic i_ready_drive_select,
  input wire logic i_dma_channel7_grant,
  input wire logic i_dma_channel6_grant,
  output logic o_dma_channel7_request,
  output logic o_dma_channel6_request,
  output logic o_bus_drive,
  output logic o_bus_master
);

  // ==========================================================
  // decoded inputs
  req_vec_t req_act; // request lines seen asserted
  logic host_req; // host asks for the bus
  logic single; // single processor system
  logic is_master; // this device owns the bus now
  logic cpa_other; // another slave asserts core priority
  logic yield; // drop own request for a core access
  logic own_request; // request placed on own line
  proc_id_t master_id_q, master_id_d; // current bus master
  proc_id_t last_id_q, last_id_d; // latest master, lowest priority when rotating

  always_comb begin
    req_act = ~i_processor_bus_request_n; // [R10]
    host_req = ~i_host_bus_request_n;
    single = (i_processor_number_inputs == `ARB_ID_NONE); // [R11]
    is_master = single || (master_id_q == i_processor_number_inputs);
    cpa_other = ~i_core_priority_access_n && ~o_core_priority_access_oe;
    // a master doing background dma gives way to a slave core
    yield = is_master && !single && i_dma_background && cpa_other; // [R16]
    own_request = i_bus_wanted && !yield;
  end

  // ==========================================================
  // request line drivers, one per shared line
  for (genvar g = 1; g <= `ARB_LINES; g++) begin : g_line
    request_line_slot #(
      .LINE(proc_id_t'(g))
    ) u_slot (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_own_id(i_processor_number_inputs),
      .i_request(own_request),
      .o_line_n(o_processor_bus_request_n[g]),
      .o_line_oe(o_processor_bus_request_oe[g])
    );
  end

  // ==========================================================
  // distributed arbitration
  // first asserted line searched upward after start, wrapping
  function automatic proc_id_t pick(req_vec_t req, proc_id_t start);
    int j;
    proc_id_t win;
    win = `ARB_ID_NONE;
    for (int k = `ARB_LINES - 1; k >= 0; k--) begin
      j = (int'(start) + k) % `ARB_LINES + 1;
      if (req[j]) begin
        win = proc_id_t'(j);
      end
    end
    return win;
  endfunction

  // every processor runs this same decision on the same lines
  always_comb begin
    master_id_d = master_id_q;
    last_id_d = last_id_q;
    if (host_req) begin
      master_id_d = master_id_q; // [R3]
    end else if (master_id_q != `ARB_ID_NONE && req_act[master_id_q]) begin
      master_id_d = master_id_q; // master keeps the bus while asking
    end else if (i_rotating_priority_select) begin
      master_id_d = pick(req_act, last_id_q); // [R14] [R20]
    end else begin
      master_id_d = pick(req_act, `ARB_LINE_LAST); // [R14] [R19]
    end
    if (master_id_d != `ARB_ID_NONE) begin
      last_id_d = master_id_d; // [R20]
    end
  end

  // register arbitration state
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      master_id_q <= `ARB_ID_NONE;
      last_id_q <= `ARB_ID_NONE;
    end else begin
      master_id_q <= master_id_d;
      last_id_q <= last_id_d;
    end
  end

  // ==========================================================
  // host hand-over and output drive
  host_state_t hstate_q, hstate_d; // hand-over state
  logic grant_n_d; // next grant level
  logic grant_oe_d; // next grant enable
  logic drive_d; // next bus drive enable
  logic ready_d; // next ready level
  logic ready_oe_d; // next ready enable
  logic cpa_oe_d; // next core priority enable

  always_comb begin
    hstate_d = hstate_q;
    case (hstate_q)
      HOST_IDLE: begin
        if (host_req && is_master) begin
          hstate_d = HOST_RELEASE; // [R1]
        end
      end
      HOST_RELEASE: begin
        hstate_d = host_req ? HOST_GRANT : HOST_IDLE; // [R1]
      end
      HOST_GRANT: begin
        if (!host_req) begin
          hstate_d = HOST_IDLE; // [R4]
        end
      end
      default: begin
        hstate_d = HOST_IDLE;
      end
    endcase
    // float the bus from the release cycle onward
    drive_d = is_master && (hstate_d == HOST_IDLE) && !host_req; // [R2]
    grant_n_d = (hstate_d != HOST_GRANT); // [R1] [R4]
    grant_oe_d = is_master; // [R5]
    // wait states only on a selected host access
    ready_oe_d = host_req && ~i_chip_select_n
      && (i_ready_drive_select || i_access_wait); // [R8] [R9]
    ready_d = ~i_access_wait; // [R7]
    cpa_oe_d = i_core_priority && !is_master && !single; // [R16] [R17]
  end

  // register host handshake, core priority and status outputs
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hstate_q <= HOST_IDLE;
      o_host_bus_grant_n <= 1'b1;
      o_host_bus_grant_oe <= 1'b0;
      o_host_access_ready <= 1'b1;
      o_host_access_ready_oe <= 1'b0;
      o_core_priority_access_n <= 1'b1;
      o_core_priority_access_oe <= 1'b0;
      o_bus_drive <= 1'b0;
      o_bus_master <= 1'b0;
    end else begin
      hstate_q <= hstate_d;
      o_host_bus_grant_n <= grant_n_d;
      o_host_bus_grant_oe <= grant_oe_d;
      o_host_access_ready <= ready_d;
      o_host_access_ready_oe <= ready_oe_d;
      o_core_priority_access_n <= ~cpa_oe_d; // open drain, low only
      o_core_priority_access_oe <= cpa_oe_d;
      o_bus_drive <= drive_d;
      o_bus_master <= is_master;
    end
  end

  // ==========================================================
  // dma request and grant pairs mapped onto channels
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_dma_channel7_request <= 1'b0;
      o_dma_channel6_request <= 1'b0;
      o_dma_grant_one_n <= 1'b1;
      o_dma_grant_two_n <= 1'b1;
    end else begin
      o_dma_channel7_request <= ~i_dma_request_one_n; // [R18]
      o_dma_channel6_request <= ~i_dma_request_two_n; // [R18]
      o_dma_grant_one_n <= ~i_dma_channel7_grant; // [R18]
      o_dma_grant_two_n <= ~i_dma_channel6_grant; // [R18]
    end
  end

  // ==========================================================
  // checks
  property p_grant_after_release;
    @(posedge i_clock) disable iff (!i_rst_n)
    (hstate_q == HOST_RELEASE && host_req) |=> !o_host_bus_grant_n;
  endproperty
  a_grant_after_release: assert property (p_grant_after_release) // [R1]
    else $error("grant missing after release");
  property p_float_under_grant;
    @(posedge i_clock) disable iff (!i_rst_n)
    !o_host_bus_grant_n |-> !o_bus_drive;
  endproperty
  a_float_under_grant: assert property (p_float_under_grant) // [R2]
    else $error("bus driven while host granted");
  property p_host_freezes_master;
    @(posedge i_clock) disable iff (!i_rst_n)
    host_req |=> master_id_q == $past(master_id_q);
  endproperty
  a_host_freezes_master: assert property (p_host_freezes_master) // [R3]
    else $error("mastership moved under host request");
  property p_grant_holds;
    @(posedge i_clock) disable iff (!i_rst_n)
    (!o_host_bus_grant_n && host_req) |=> !o_host_bus_grant_n;
  endproperty
  a_grant_holds: assert property (p_grant_holds) // [R4]
    else $error("grant dropped while request held");
  property p_grant_by_master;
    @(posedge i_clock) disable iff (!i_rst_n)
    o_host_bus_grant_oe |-> o_bus_master;
  endproperty
  a_grant_by_master: assert property (p_grant_by_master) // [R5]
    else $error("grant driven by non master");
  property p_open_drain_ready;
    @(posedge i_clock) disable iff (!i_rst_n)
    (o_host_access_ready_oe && !$past(i_ready_drive_select))
      |-> !o_host_access_ready;
  endproperty
  a_open_drain_ready: assert property (p_open_drain_ready) // [R8]
    else $error("open drain ready driven high");
  property p_ready_gate;
    @(posedge i_clock) disable iff (!i_rst_n)
    o_host_access_ready_oe |-> $past(host_req && !i_chip_select_n);
  endproperty
  a_ready_gate: assert property (p_ready_gate) // [R9]
    else $error("ready driven without select and request");
  property p_one_line;
    @(posedge i_clock) disable iff (!i_rst_n)
    $onehot0(o_processor_bus_request_oe) && (o_processor_bus_request_oe
      == '0 || o_processor_bus_request_oe[i_processor_number_inputs]);
  endproperty
  a_one_line: assert property (p_one_line) // [R10] [R11]
    else $error("wrong request line driven");
  property p_yield;
    @(posedge i_clock) disable iff (!i_rst_n)
    yield |=> o_processor_bus_request_n[$past(i_processor_number_inputs)];
  endproperty
  a_yield: assert property (p_yield) // [R16]
    else $error("master kept request under core priority");
  property p_dma_map;
    @(posedge i_clock) disable iff (!i_rst_n)
    ##1 (o_dma_channel7_request == !$past(i_dma_request_one_n))
      && (o_dma_grant_two_n == !$past(i_dma_channel6_grant));
  endproperty
  a_dma_map: assert property (p_dma_map) // [R18]
    else $error("dma pair mapped to wrong channel");
endmodule

// ===== hw/request_line_slot.sv
// drive stage for one shared processor bus request line
`timescale 1ns/1ps
`include "bus_arb_regs.svh"
module request_line_slot
  import bus_arb_pkg::*;
#(
  parameter proc_id_t LINE = `ARB_LINE_FIRST
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // processor number and own request
  input wire proc_id_t i_own_id,
  input wire logic i_request,
  // pin drive, active low line with enable
  output logic o_line_n,
  output logic o_line_oe
);
  logic line_n_d; // next pin level
  logic line_oe_d; // next pin enable

  // only the line picked by the number inputs is driven
  always_comb begin
    line_oe_d = (i_own_id == LINE); // [R10] [R11]
    line_n_d = ~(i_request && line_oe_d);
  end

  // register the pin drive
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_line_n <= 1'b1;
      o_line_oe <= 1'b0;
    end else begin
      o_line_n <= line_n_d;
      o_line_oe <= line_oe_d;
    end
  end
endmodule
